/* File: bench/psc_chk.sv */
// Concurrent checks on the power state controller ports
module psc_chk (
  // Clock, reset and inputs
  input logic ref_clk_i,
  input logic nrst_i,
  input logic por_ok_i,
  input logic sys_lo_ok_i,
  input logic off_req_i,
  input logic irq_pending_i,
  // Outputs
  input logic otp_rd_o,
  input logic res_wr_o,
  input logic res_load_default_o,
  input logic res_force_off_o,
  input logic always_on_rail_o,
  input logic sleep_mode_o,
  input logic [4:0] pwr_state_o,
  input logic seq_busy_o,
  input logic seq_halted_o,
  input logic integrity_error_interrupt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // ****
  // Cycles since the last resource write
  // ****
  logic [10:0] gap_r;
  logic seen_r;
  always_ff @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      gap_r <= 11'h000;
      seen_r <= 1'b0;
    end else if (res_wr_o) begin
      gap_r <= 11'h000;
      seen_r <= 1'b1;
    end else if (gap_r != 11'h7FF) begin
      gap_r <= gap_r + 11'h001;
    end
  end
  chk_nosup_state: assert property (
    (!por_ok_i) [*5] |-> pwr_state_o == 5'h01 && !seq_busy_o) else $error("no-supply state not taken");
  chk_backup_state: assert property (
    (por_ok_i && !sys_lo_ok_i) [*5] |-> pwr_state_o == 5'h02) else $error("backup state not taken");
  chk_idle_off: assert property (
    (pwr_state_o == 5'h04 && !seq_busy_o && !seq_halted_o) [*3] |-> res_force_off_o) else $error("off not forced");
  chk_rail_up: assert property (
    (pwr_state_o != 5'h01) [*2] |-> always_on_rail_o) else $error("always-on rail down");
  chk_low_quiet: assert property (
    pwr_state_o inside {5'h01, 5'h02} |-> !res_wr_o && !otp_rd_o) else $error("sequencing without supply");
  chk_load_entry: assert property (
    res_load_default_o |-> pwr_state_o == 5'h04 && $past(pwr_state_o) inside {5'h01, 5'h02})
    else $error("defaults loaded outside off entry");
  chk_legal_exit: assert property (
    $past(pwr_state_o) == 5'h04 && pwr_state_o != 5'h04 |-> pwr_state_o inside {5'h08, 5'h01, 5'h02})
    else $error("illegal exit from off");
  chk_sleep_flag: assert property (
    $stable(pwr_state_o) |-> sleep_mode_o == (pwr_state_o == 5'h10)) else $error("sleep mode flag wrong");
  chk_step_gap: assert property (
    res_wr_o && seen_r |-> gap_r >= 11'h5F4) else $error("steps closer than one slow tick");
  chk_wr_from_otp: assert property (
    res_wr_o |-> $past(otp_rd_o, 2) || $past(otp_rd_o, 3)) else $error("write without step fetch");
  chk_err_pulse: assert property (
    integrity_error_interrupt_o |-> $past(seq_busy_o) && pwr_state_o == 5'h04 ##1 !integrity_error_interrupt_o)
    else $error("integrity flag misplaced");
  chk_sleep_gate: assert property (
    $rose(seq_busy_o) && pwr_state_o == 5'h08 && !$past(off_req_i, 3) |-> !$past(irq_pending_i, 3))
    else $error("sleep taken with interrupt pending");
  cov_sleep: cover property (pwr_state_o == 5'h10);
  cov_err: cover property (integrity_error_interrupt_o);
  cov_partial: cover property (seq_halted_o && pwr_state_o == 5'h08);
endmodule // psc_chk

bind psc_power_state_controller psc_chk u_chk (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .por_ok_i(por_ok_i), .sys_lo_ok_i(sys_lo_ok_i),
  .off_req_i(off_req_i), .irq_pending_i(irq_pending_i), .otp_rd_o(otp_rd_o), .res_wr_o(res_wr_o),
  .res_load_default_o(res_load_default_o), .res_force_off_o(res_force_off_o),
  .always_on_rail_o(always_on_rail_o), .sleep_mode_o(sleep_mode_o), .pwr_state_o(pwr_state_o),
  .seq_busy_o(seq_busy_o), .seq_halted_o(seq_halted_o),
  .integrity_error_interrupt_o(integrity_error_interrupt_o)
);

/* File: bench/psc_otp_model.sv */
// OTP model: fixed sequence steps, check option word and signature
module psc_otp_model (
  // Read port
  input logic ref_clk_i,
  input logic rd_i,
  input logic [7:0] addr_i,
  output logic [15:0] data_o,
  // Programmed option and fault
  input logic [1:0] mode_i,
  input logic corrupt_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sig;
  // Code 0 has three steps with the IO rail at step 1, codes 1 to 4 two, codes 5 to 7 none; contents never change
  function automatic logic [15:0] word(input logic [7:0] a);
    logic [15:0] x;
    int n;
    n = (a[7:5] == 3'h0) ? 3 : 2;
    x = 16'h0000;
    if (a < 8'hA0 && a[4:0] < n) begin
      x = {a[4:0] == n - 1, a[7:5] == 3'h0 && a[4:0] == 5'h01, a[7:5], a[2:0], 2'h2, a[7:5], a[2:0]};
    end
    return x;
  endfunction
  always_comb begin
    sig = 16'h0000;
    for (int a = 0; a < 240; a++) begin
      sig ^= word(a[7:0]);
    end
  end
  // Outside the answer cycle the bus toggles so stale data never looks valid
  always @(posedge ref_clk_i) begin
    if (rd_i) begin
      data_o <= (addr_i == 8'hF0) ? {14'h0000, mode_i} :
                (addr_i == 8'hF1) ? sig ^ {15'h0000, corrupt_i} : word(addr_i);
    end else begin
      data_o <= ~data_o;
    end
  end
  initial data_o = 16'hA5A5;
endmodule // psc_otp_model

/* File: bench/psc_power_state_controller_tb_top.sv */
// Self-checking testbench of the power state controller
module psc_power_state_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, nrst_i, por, lo, hi, hot, irq, corrupt;
  logic otp_rd, res_wr, res_ld, res_off, aon, slp_m, busy, halted, ierr;
  logic [4:0] rq, state;
  logic [1:0] mode;
  logic [7:0] otp_addr, res_data;
  logic [5:0] res_addr;
  logic [15:0] otp_data;
  int miscompares = 0, total_checks = 0, cycles = 0, ierr_cnt = 0;
  // Request vector: on, off, sleep, wake, wake-to-off
  psc_power_state_controller dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .por_ok_i(por), .sys_lo_ok_i(lo), .sys_hi_ok_i(hi),
    .hot_die_i(hot), .on_req_i(rq[4]), .off_req_i(rq[3]), .sleep_req_i(rq[2]), .wake_req_i(rq[1]),
    .wake_to_off_i(rq[0]), .irq_pending_i(irq), .otp_rd_o(otp_rd), .otp_addr_o(otp_addr),
    .otp_data_i(otp_data), .res_wr_o(res_wr), .res_addr_o(res_addr), .res_data_o(res_data),
    .res_load_default_o(res_ld), .res_force_off_o(res_off), .always_on_rail_o(aon),
    .sleep_mode_o(slp_m), .pwr_state_o(state), .seq_busy_o(busy), .seq_halted_o(halted),
    .integrity_error_interrupt_o(ierr)
  );
  psc_otp_model u_otp (
    .ref_clk_i(ref_clk_i), .rd_i(otp_rd), .addr_i(otp_addr), .data_o(otp_data),
    .mode_i(mode), .corrupt_i(corrupt)
  );
  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // Longest run is about nine sequences of two slow ticks each
  always @(posedge ref_clk_i) begin
    cycles++;
    if (ierr === 1'b1) ierr_cnt++;
    if (cycles == 90000) begin
      miscompares++;
      finish_test();
    end
  end
  // ****
  // Shared tasks
  // ****
  task finish_test();
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task wait_busy(input logic v);
    for (int i = 0; i < 4000 && busy !== v; i++) cyc(1);
    check("seq_busy_o", busy, v);
  endtask
  task exp_seq(input logic [2:0] c, input int n);
    for (int s = 0; s < n; s++) begin
      for (int i = 0; i < 3000 && res_wr !== 1'b1; i++) cyc(1);
      check("res_addr_o", res_addr, {c, s[2:0]});
      check("res_data_o", res_data, {2'h2, c, s[2:0]});
      cyc(1);
    end
    wait_busy(1'b0);
    // State, halt flag and error count settle one edge after busy drops
    cyc(2);
  endtask
  // Requests held until the sequencer takes them
  task go(input logic [4:0] r, input logic [2:0] c, input int n, input logic [4:0] st);
    rq = r;
    wait_busy(1'b1);
    rq = 5'h00;
    exp_seq(c, n);
    check("pwr_state_o", state, st);
  endtask
  task refused(input logic [4:0] r);
    rq = r;
    cyc(20);
    check("seq_busy_o", busy, 1'b0);
    rq = 5'h00;
    cyc(3);
  endtask
  task up(input logic [1:0] m, input logic bad, input int n, input logic [4:0] st, input logic h);
    int e;
    e = ierr_cnt;
    mode = m;
    corrupt = bad;
    go(5'h10, 3'h0, n, st);
    check("seq_halted_o", halted, h);
    check("ierr_count", 16'(ierr_cnt - e), 16'(bad && m != 2'h0));
  endtask
  // ****
  // Scenarios
  // ****
  task t_supply();
    int n;
    n = 0;
    check("pwr_state_o", state, 5'h01);
    check("res_force_off_o", res_off, 1'b1);
    por = 1'b1;
    cyc(6);
    check("pwr_state_o", state, 5'h02);
    check("always_on_rail_o", aon, 1'b1);
    lo = 1'b1;
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      if (res_ld === 1'b1) n++;
    end
    check("load_pulses", 16'(n), 16'h0001);
    check("pwr_state_o", state, 5'h04);
    check("res_force_off_o", res_off, 1'b1);
  endtask
  task t_loss();
    por = 1'b0;
    cyc(6);
    check("pwr_state_o", state, 5'h01);
    check("always_on_rail_o", aon, 1'b0);
    check("seq_busy_o", busy, 1'b0);
  endtask
  initial begin
    nrst_i = 1'b0;
    {por, lo, hi, hot, irq, corrupt} = 6'h00;
    rq = 5'h00;
    mode = 2'h0;
    cyc(10);
    nrst_i = 1'b1;
    t_supply();
    refused(5'h10);
    hi = 1'b1;
    hot = 1'b1;
    refused(5'h10);
    hot = 1'b0;
    refused(5'h18);
    up(2'h3, 1'b1, 0, 5'h04, 1'b1);
    up(2'h2, 1'b1, 2, 5'h08, 1'b1);
    go(5'h0C, 3'h1, 2, 5'h04);
    up(2'h1, 1'b1, 3, 5'h08, 1'b0);
    irq = 1'b1;
    refused(5'h06);
    irq = 1'b0;
    cyc(5);
    go(5'h04, 3'h2, 2, 5'h10);
    check("sleep_mode_o", slp_m, 1'b1);
    go(5'h02, 3'h3, 2, 5'h08);
    go(5'h04, 3'h2, 2, 5'h10);
    go(5'h03, 3'h4, 2, 5'h04);
    up(2'h0, 1'b1, 3, 5'h08, 1'b0);
    t_loss();
    finish_test();
  end
endmodule // psc_power_state_controller_tb_top

/* File: include/psc_regs.vh */
// Constants of the power state controller: timing, OTP map, step format, codes
`ifndef PSC_REGS_VH
`define PSC_REGS_VH

// ****************************************************************
// Timing
// ****************************************************************
`define PSC_CLK_HZ 50000000
`define PSC_SEQ_HZ 32768
`define PSC_TICK_DIV (`PSC_CLK_HZ / `PSC_SEQ_HZ)
`define PSC_DIV_W 11

// ****************************************************************
// OTP map
// ****************************************************************
`define PSC_OTP_AW 8
`define PSC_OTP_DW 16
`define PSC_OTP_CHK_FIRST 8'h00
`define PSC_OTP_CHK_LAST 8'hEF
`define PSC_OTP_MODE_ADDR 8'hF0
`define PSC_OTP_SUM_ADDR 8'hF1
`define PSC_SUM_RESET 16'h0000
`define PSC_MODE_HI 1
`define PSC_MODE_LO 0

// Each sequence owns 32 words, base = code * 32
`define PSC_STEP_W 5
`define PSC_STEP_FIRST 5'h00

// ****************************************************************
// Step word format
// ****************************************************************
`define PSC_STEP_LAST 15
`define PSC_STEP_IO 14
`define PSC_STEP_ADDR_HI 13
`define PSC_STEP_ADDR_LO 8
`define PSC_STEP_DATA_HI 7
`define PSC_STEP_DATA_LO 0
`define PSC_RES_AW 6
`define PSC_RES_DW 8

// ****************************************************************
// Sequence codes
// ****************************************************************
`define PSC_SEQ_OFF_TO_ACTIVE_SEQUENCE 3'h0
`define PSC_SEQ_ACTIVE_TO_OFF_SEQUENCE 3'h1
`define PSC_SEQ_ACTIVE_TO_SLEEP_SEQUENCE 3'h2
`define PSC_SEQ_SLEEP_TO_ACTIVE_SEQUENCE 3'h3
`define PSC_SEQ_SLEEP_TO_OFF_SEQUENCE 3'h4

// ****************************************************************
// Integrity check options
// ****************************************************************
`define PSC_CHK_SKIP 2'h0
`define PSC_CHK_GO 2'h1
`define PSC_CHK_TO_IO 2'h2
`define PSC_CHK_HALT 2'h3

// ****************************************************************
// Synchroniser bit positions
// ****************************************************************
`define PSC_NSYNC 10
`define PSC_S_POR 0
`define PSC_S_LO 1
`define PSC_S_HI 2
`define PSC_S_HOT 3
`define PSC_S_ON 4
`define PSC_S_OFF 5
`define PSC_S_SLP 6
`define PSC_S_WAKE 7
`define PSC_S_WOFF 8
`define PSC_S_IRQ 9

`endif

/* File: logic/psc_power_state_controller.v */
// Embedded power controller: arbitration, power state machine and OTP sequencer
`include "psc_regs.vh"

module psc_power_state_controller (
  // Clock and reset
  input wire ref_clk_i,
  input wire nrst_i,
  // Supply and temperature monitors
  input wire por_ok_i,
  input wire sys_lo_ok_i,
  input wire sys_hi_ok_i,
  input wire hot_die_i,
  // Power requests
  input wire on_req_i,
  input wire off_req_i,
  input wire sleep_req_i,
  input wire wake_req_i,
  input wire wake_to_off_i,
  input wire irq_pending_i,
  // OTP read port
  output reg otp_rd_o,
  output reg [`PSC_OTP_AW-1:0] otp_addr_o,
  input wire [`PSC_OTP_DW-1:0] otp_data_i,
  // Resource register write port
  output reg res_wr_o,
  output reg [`PSC_RES_AW-1:0] res_addr_o,
  output reg [`PSC_RES_DW-1:0] res_data_o,
  output reg res_load_default_o,
  output reg res_force_off_o,
  output reg always_on_rail_o,
  output reg sleep_mode_o,
  // Status
  output reg [4:0] pwr_state_o,
  output reg seq_busy_o,
  output reg seq_halted_o,
  output reg integrity_error_interrupt_o
);

  // ****************************************************************
  // Power and sequencer states
  // ****************************************************************
  localparam [4:0] P_NOSUP = 5'h01;
  localparam [4:0] P_BACKUP = 5'h02;
  localparam [4:0] P_OFF = 5'h04;
  localparam [4:0] P_ACTIVE = 5'h08;
  localparam [4:0] P_SLEEP = 5'h10;

  localparam [9:0] Q_IDLE = 10'h001;
  localparam [9:0] Q_MODE_RD = 10'h002;
  localparam [9:0] Q_MODE_ACC = 10'h004;
  localparam [9:0] Q_CHK_RD = 10'h008;
  localparam [9:0] Q_CHK_ACC = 10'h010;
  localparam [9:0] Q_SUM_RD = 10'h020;
  localparam [9:0] Q_SUM_CMP = 10'h040;
  localparam [9:0] Q_STEP_WAIT = 10'h080;
  localparam [9:0] Q_STEP_EXEC = 10'h100;
  localparam [9:0] Q_STEP_RD = 10'h200;

  localparam integer TICK_LAST_I = `PSC_TICK_DIV - 1;
  localparam [`PSC_DIV_W-1:0] TICK_LAST = TICK_LAST_I[`PSC_DIV_W-1:0];
  localparam [`PSC_DIV_W-1:0] TICK_ZERO = 11'h000;

  // OTP address of a step within a sequence
  function [`PSC_OTP_AW-1:0] seq_addr;
    input [2:0] code;
    input [`PSC_STEP_W-1:0] step;
    begin
      seq_addr = {code, step};
    end
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  wire [`PSC_NSYNC-1:0] raw_in;
  reg [`PSC_NSYNC-1:0] meta_r;
  reg [`PSC_NSYNC-1:0] sync_r;

  assign raw_in = {irq_pending_i, wake_to_off_i, wake_req_i, sleep_req_i, off_req_i,
                   on_req_i, hot_die_i, sys_hi_ok_i, sys_lo_ok_i, por_ok_i};

  genvar g;
  generate
    for (g = 0; g < `PSC_NSYNC; g = g + 1) begin : g_sync
      always @(posedge ref_clk_i) begin
        if (!nrst_i) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= raw_in[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  wire por_ok = sync_r[`PSC_S_POR];
  wire lo_ok = sync_r[`PSC_S_LO];
  wire hi_ok = sync_r[`PSC_S_HI];
  wire hot = sync_r[`PSC_S_HOT];
  wire on_req = sync_r[`PSC_S_ON];
  wire off_req = sync_r[`PSC_S_OFF];
  wire slp_req = sync_r[`PSC_S_SLP];
  wire wake_req = sync_r[`PSC_S_WAKE];
  wire wake_off = sync_r[`PSC_S_WOFF];
  wire irq_pend = sync_r[`PSC_S_IRQ];

  // ****************************************************************
  // 32 kHz step tick
  // ****************************************************************
  reg [`PSC_DIV_W-1:0] div_r;
  reg tick_r;

  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      div_r <= TICK_ZERO;
      tick_r <= 1'b0;
    end else if (div_r == TICK_LAST) begin
      div_r <= TICK_ZERO;
      tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 11'h001;
      tick_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  reg [4:0] pst_r;
  reg [4:0] pst_nxt;
  reg [9:0] sq_r;
  reg [9:0] sq_nxt;
  reg done_r;
  reg arb_go;
  reg [2:0] arb_seq;
  reg [4:0] arb_tgt;
  wire sq_idle = (sq_r == Q_IDLE);

  // Requests are only taken while the sequencer is idle, so a sequence
  // runs to its end unless the supply collapses under it or an integrity failure halts or stops it early.
  always @* begin
    arb_go = 1'b0;
    arb_seq = `PSC_SEQ_OFF_TO_ACTIVE_SEQUENCE;
    arb_tgt = P_ACTIVE;
    // The state has not yet moved in the cycle a sequence ends, so hold off then
    if (sq_idle && !done_r && lo_ok && por_ok) begin
      case (pst_r)
        P_OFF: begin
          // Held off request blocks power-up until it is released
          if (on_req && hi_ok && !hot && !off_req) begin
            arb_go = 1'b1;
            arb_seq = `PSC_SEQ_OFF_TO_ACTIVE_SEQUENCE;
            arb_tgt = P_ACTIVE;
          end
        end
        P_ACTIVE: begin
          if (off_req) begin
            arb_go = 1'b1;
            arb_seq = `PSC_SEQ_ACTIVE_TO_OFF_SEQUENCE;
            arb_tgt = P_OFF;
          end else if (slp_req && !irq_pend) begin
            arb_go = 1'b1;
            arb_seq = `PSC_SEQ_ACTIVE_TO_SLEEP_SEQUENCE;
            arb_tgt = P_SLEEP;
          end
        end
        P_SLEEP: begin
          if (off_req) begin
            arb_go = 1'b1;
            arb_seq = `PSC_SEQ_SLEEP_TO_OFF_SEQUENCE;
            arb_tgt = P_OFF;
          end else if (wake_req) begin
            arb_go = 1'b1;
            arb_seq = wake_off ? `PSC_SEQ_SLEEP_TO_OFF_SEQUENCE : `PSC_SEQ_SLEEP_TO_ACTIVE_SEQUENCE;
            arb_tgt = wake_off ? P_OFF : P_ACTIVE;
          end
        end
        default: begin
          arb_go = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  reg [2:0] seq_r;
  reg [4:0] tgt_r;
  reg [`PSC_STEP_W-1:0] step_r;
  reg [`PSC_OTP_AW-1:0] chk_addr_r;
  reg [`PSC_OTP_DW-1:0] sum_r;
  reg [1:0] mode_r;
  reg stop_io_r;
  reg halt_r;
  wire abort = !lo_ok || !por_ok;
  wire step_last = otp_data_i[`PSC_STEP_LAST];
  wire step_io_stop = stop_io_r && otp_data_i[`PSC_STEP_IO];

  always @* begin
    sq_nxt = sq_r;
    case (sq_r)
      Q_IDLE: begin
        if (arb_go) begin
          sq_nxt = (arb_seq == `PSC_SEQ_OFF_TO_ACTIVE_SEQUENCE) ? Q_MODE_RD : Q_STEP_WAIT;
        end
      end
      Q_MODE_RD: sq_nxt = Q_MODE_ACC;
      Q_MODE_ACC: begin
        if (otp_data_i[`PSC_MODE_HI:`PSC_MODE_LO] == `PSC_CHK_SKIP) begin
          sq_nxt = Q_STEP_WAIT;
        end else begin
          sq_nxt = Q_CHK_RD;
        end
      end
      Q_CHK_RD: sq_nxt = Q_CHK_ACC;
      Q_CHK_ACC: sq_nxt = (chk_addr_r == `PSC_OTP_CHK_LAST) ? Q_SUM_RD : Q_CHK_RD;
      Q_SUM_RD: sq_nxt = Q_SUM_CMP;
      Q_SUM_CMP: begin
        if (otp_data_i != sum_r && mode_r == `PSC_CHK_HALT) begin
          sq_nxt = Q_IDLE;
        end else begin
          sq_nxt = Q_STEP_WAIT;
        end
      end
      Q_STEP_WAIT: sq_nxt = tick_r ? Q_STEP_RD : Q_STEP_WAIT;
      // OTP answers in the cycle after the strobe, as for the check reads
      Q_STEP_RD: sq_nxt = Q_STEP_EXEC;
      Q_STEP_EXEC: sq_nxt = (step_last || step_io_stop) ? Q_IDLE : Q_STEP_WAIT;
      default: sq_nxt = Q_IDLE;
    endcase
    if (abort) begin
      sq_nxt = Q_IDLE;
    end
  end

  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      sq_r <= Q_IDLE;
      seq_r <= `PSC_SEQ_OFF_TO_ACTIVE_SEQUENCE;
      tgt_r <= P_OFF;
      step_r <= `PSC_STEP_FIRST;
      chk_addr_r <= `PSC_OTP_CHK_FIRST;
      sum_r <= `PSC_SUM_RESET;
      mode_r <= `PSC_CHK_SKIP;
      stop_io_r <= 1'b0;
      done_r <= 1'b0;
      halt_r <= 1'b0;
      otp_rd_o <= 1'b0;
      otp_addr_o <= `PSC_OTP_CHK_FIRST;
      res_wr_o <= 1'b0;
      res_addr_o <= 6'h00;
      res_data_o <= 8'h00;
      integrity_error_interrupt_o <= 1'b0;
    end else begin
      sq_r <= sq_nxt;
      otp_rd_o <= 1'b0;
      res_wr_o <= 1'b0;
      done_r <= 1'b0;
      integrity_error_interrupt_o <= 1'b0;
      case (sq_r)
        Q_IDLE: begin
          if (arb_go && !abort) begin
            seq_r <= arb_seq;
            tgt_r <= arb_tgt;
            step_r <= `PSC_STEP_FIRST;
            stop_io_r <= 1'b0;
            halt_r <= 1'b0;
            sum_r <= `PSC_SUM_RESET;
            chk_addr_r <= `PSC_OTP_CHK_FIRST;
            if (arb_seq == `PSC_SEQ_OFF_TO_ACTIVE_SEQUENCE) begin
              otp_rd_o <= 1'b1;
              otp_addr_o <= `PSC_OTP_MODE_ADDR;
            end
          end
        end
        Q_MODE_ACC: begin
          mode_r <= otp_data_i[`PSC_MODE_HI:`PSC_MODE_LO];
          otp_rd_o <= 1'b1;
          otp_addr_o <= chk_addr_r;
        end
        Q_CHK_ACC: begin
          // Running XOR of the checked region against a stored signature
          sum_r <= sum_r ^ otp_data_i;
          if (chk_addr_r == `PSC_OTP_CHK_LAST) begin
            otp_rd_o <= 1'b1;
            otp_addr_o <= `PSC_OTP_SUM_ADDR;
          end else begin
            chk_addr_r <= chk_addr_r + 8'h01;
            otp_rd_o <= 1'b1;
            otp_addr_o <= chk_addr_r + 8'h01;
          end
        end
        Q_SUM_CMP: begin
          if (otp_data_i != sum_r) begin
            integrity_error_interrupt_o <= 1'b1;
            stop_io_r <= (mode_r == `PSC_CHK_TO_IO);
            halt_r <= (mode_r == `PSC_CHK_HALT);
            done_r <= (mode_r == `PSC_CHK_HALT);
          end
        end
        Q_STEP_WAIT: begin
          if (tick_r && !abort) begin
            otp_rd_o <= 1'b1;
            otp_addr_o <= seq_addr(seq_r, step_r);
          end
        end
        Q_STEP_EXEC: begin
          if (!abort) begin
            // Only the addressed resource changes; all others keep their values
            res_wr_o <= 1'b1;
            res_addr_o <= otp_data_i[`PSC_STEP_ADDR_HI:`PSC_STEP_ADDR_LO];
            res_data_o <= otp_data_i[`PSC_STEP_DATA_HI:`PSC_STEP_DATA_LO];
            step_r <= step_r + 5'h01;
            if (step_io_stop && !step_last) begin
              halt_r <= 1'b1;
            end
            done_r <= step_last || step_io_stop;
          end
        end
        default: begin
          otp_rd_o <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Power state machine
  // ****************************************************************
  always @* begin
    pst_nxt = pst_r;
    if (!por_ok) begin
      pst_nxt = P_NOSUP;
    end else if (!lo_ok) begin
      pst_nxt = P_BACKUP;
    end else begin
      case (pst_r)
        P_NOSUP, P_BACKUP: pst_nxt = P_OFF;
        P_OFF, P_ACTIVE, P_SLEEP: begin
          // A halted power-up stays off; a stop at the IO rail still ends active
          if (done_r && (!halt_r || stop_io_r)) begin
            pst_nxt = tgt_r;
          end
        end
        default: pst_nxt = P_NOSUP;
      endcase
    end
  end

  always @(posedge ref_clk_i) begin
    if (!nrst_i) begin
      pst_r <= P_NOSUP;
      res_load_default_o <= 1'b0;
      res_force_off_o <= 1'b1;
      always_on_rail_o <= 1'b0;
      sleep_mode_o <= 1'b0;
      pwr_state_o <= P_NOSUP;
      seq_busy_o <= 1'b0;
      seq_halted_o <= 1'b0;
    end else begin
      pst_r <= pst_nxt;
      pwr_state_o <= pst_nxt;
      // Defaults reloaded by hardware on the way up into off
      res_load_default_o <= (pst_nxt == P_OFF) &&
                            ((pst_r == P_NOSUP) || (pst_r == P_BACKUP));
      res_force_off_o <= (pst_nxt == P_NOSUP) || (pst_nxt == P_BACKUP) ||
                         ((pst_nxt == P_OFF) && (sq_nxt == Q_IDLE) && !seq_halted_o);
      always_on_rail_o <= (pst_nxt != P_NOSUP);
      // Regulators apply their sleep setting and keep linked loads up
      sleep_mode_o <= (pst_nxt == P_SLEEP);
      seq_busy_o <= (sq_nxt != Q_IDLE);
      if (done_r) begin
        seq_halted_o <= halt_r;
      end else if (abort || (arb_go && sq_idle)) begin
        seq_halted_o <= 1'b0;
      end
    end
  end

endmodule // psc_power_state_controller
